// ---- rtl/pixel_array_readout_sequencer.sv ----
// pixel array readout sequencer: shutter modes, window, mirror, subsampling
// Contract
// R1: rolling mode streams frames at fixed rate, resetting then reading rows.
// R2: reset-to-read interval is equal for every row of a frame.
// R3: exposure changes take effect only at frame boundaries.
// R4: global mode captures one frame; drives mechanical shutter controls.
// R5: window bounds sequencing; output width and height limit delivered image.
// R6: default window reads 3840 by 2748, border up to 8 reachable.
// R7: mirror reads each row from last column to first.
// R8: flip reads rows from last row to first.
// R9: readable colour order follows mirror and flip.
// R10: horizontal skip up to 4x, vertical skip up to 32x.
// R11: horizontal skip shortens rows; vertical skip reduces rows read.
// R12: skipping alone reads every second or fourth pixel pair.
// R13: binning averages, summing adds the combined pixels.
// R14: summing pairs same-colour neighbours; binning adjacent or alternate.
// R15: skip plus sum sums neighbours then skips the next group.
// R16: at 4x or more, summing still combines neighbours.
// R17: host never sets two-axis binning with vertical summing.
// R18: host uses two-axis binning only with vertical skip up to 4x.
// R19: host keeps combine modes to the legal skip combinations.
// R20: mirror, flip and skip act independently on the frame's window.
//
// The plain strobed port and the address map are this design's own decisions.
`include "readout_params.svh"
module pixel_array_readout_sequencer
  import readout_pkg::*;
#(
  parameter int LINE_BLANK = 16
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  output logic             row_rst_o,
  output logic      [11:0] rst_row_o,
  output logic             pix_valid_o,
  output logic      [11:0] col_addr_o,
  output logic      [11:0] row_addr_o,
  output logic      [11:0] nbr_col_o,
  output logic             frame_start_o,
  output logic             comb_bin_o,
  output logic             comb_sum_o,
  output logic             comb_vert_o,
  output logic             global_rst_o,
  output logic             shutter_open_o
);
  localparam logic [7:0] GR_CYC = 8'(`GR_RST_CYC);
  localparam logic [7:0] BLANK  = 8'(LINE_BLANK - 1);

  logic [4:0]  ctrl_ff;
  logic [11:0] x_start_ff, x_end_ff, y_start_ff, y_end_ff;
  logic [11:0] x_out_ff, y_out_ff, exp_ff;
  logic [9:0]  sub_ff;
  frame_cfg_t  fr_ff;
  seq_state_t  state_ff;
  logic [7:0]  gr_cnt_ff, blank_cnt_ff;
  logic        walk_ff, rs_act_ff, rd_act_ff;
  logic [12:0] co_ff, rs_o_ff, rd_o_ff, step_ff;
  logic [11:0] out_row_ff, out_col_ff;
  logic [15:0] frame_cnt_ff;

  // live settings gathered for latching at a frame start
  frame_cfg_t cfg_w;
  assign cfg_w = '{global_mode: ctrl_ff[`CTRL_GLOBAL],
                   mirror: ctrl_ff[`CTRL_MIRROR], flip: ctrl_ff[`CTRL_FLIP],
                   x_start: x_start_ff, x_end: x_end_ff,
                   y_start: y_start_ff, y_end: y_end_ff,
                   x_out: x_out_ff, y_out: y_out_ff, exposure: exp_ff,
                   skip_x: sub_ff[`SUB_SKX_LSB +: 2],
                   skip_y: sub_ff[`SUB_SKY_LSB +: 3],
                   combine: sub_ff[`SUB_BINALT:`SUB_BINX]};

  // subsample steps: read a bayer pair, then jump 2k-1
  wire [12:0] kx_step  = 13'((2 << fr_ff.skip_x) - 1); // R10 R12
  wire [12:0] ky_step  = 13'((2 << fr_ff.skip_y) - 1); // R10 R12
  wire [12:0] span_x   = {1'b0, fr_ff.x_end - fr_ff.x_start};
  wire [12:0] span_y   = {1'b0, fr_ff.y_end - fr_ff.y_start};
  wire [12:0] nxt_co   = co_ff[0] ? co_ff + kx_step : co_ff + 13'h0001;
  wire [12:0] nxt_rs_o = rs_o_ff[0] ? rs_o_ff + ky_step : rs_o_ff + 13'h0001;
  wire [12:0] nxt_rd_o = rd_o_ff[0] ? rd_o_ff + ky_step : rd_o_ff + 13'h0001;
  wire        step_tick = (state_ff == ST_RUN) && !walk_ff
                          && (blank_cnt_ff == BLANK);
  wire        rd_done  = rd_act_ff && (nxt_rd_o > span_y);
  wire        frame_end = step_tick && rd_done;
  wire        roll_go  = ctrl_ff[`CTRL_STREAM] && !ctrl_ff[`CTRL_GLOBAL];
  wire        trig_w   = reg_wr_i && (reg_addr_i == `REG_CTRL)
                         && reg_wdata_i[`CTRL_TRIGGER];
  wire        start_w  = ((state_ff == ST_IDLE) && roll_go)
                         || ((state_ff == ST_GRST) && (gr_cnt_ff == GR_CYC))
                         || (frame_end && !fr_ff.global_mode && roll_go);
  // mirror/flip applied around the frame's own window
  wire [11:0] col_w = fr_ff.mirror ? fr_ff.x_end - co_ff[11:0]
                                   : fr_ff.x_start + co_ff[11:0]; // R7 R20
  wire [11:0] rd_row_w = fr_ff.flip ? fr_ff.y_end - rd_o_ff[11:0]
                                    : fr_ff.y_start + rd_o_ff[11:0]; // R8 R20
  wire [11:0] rs_row_w = fr_ff.flip ? fr_ff.y_end - rs_o_ff[11:0]
                                    : fr_ff.y_start + rs_o_ff[11:0];
  // same-colour neighbour two columns away, four for alternate binning
  wire [11:0] nbr_d_w = fr_ff.combine[4] ? 12'h004 : 12'h002; // R14
  wire        comb_h_w = |fr_ff.combine[3:0];
  wire [1:0]  order_w = {ctrl_ff[`CTRL_FLIP] ? y_end_ff[0] : y_start_ff[0],
                         ctrl_ff[`CTRL_MIRROR] ? x_end_ff[0]
                                               : x_start_ff[0]}; // R9
  wire [4:0]  cmb = sub_ff[`SUB_BINALT:`SUB_BINX];
  wire        cfg_err = (cmb[1] && cmb[3])
                        || (cmb[1] && sub_ff[`SUB_SKY_LSB +: 3] > 3'h2)
                        || ((cmb[0] | cmb[2])
                            && sub_ff[`SUB_SKX_LSB +: 2] == 2'h0)
                        || ((cmb[1] | cmb[3])
                            && sub_ff[`SUB_SKX_LSB +: 2] == 2'h0
                            && sub_ff[`SUB_SKY_LSB +: 3] == 3'h0)
                        || sub_ff[`SUB_SKX_LSB +: 2] == 2'h3
                        || sub_ff[`SUB_SKY_LSB +: 3] > 3'h5; // R17 R18 R19
  wire [15:0] status_w = {frame_cnt_ff[10:0], cfg_err,
                          state_ff != ST_IDLE, order_w, 1'b0};
  logic [15:0] nxt_rdata;
  always_comb begin
    case (reg_addr_i)
      `REG_CTRL:      nxt_rdata = {12'h000, ctrl_ff[3:0]};
      `REG_X_START:   nxt_rdata = {4'h0, x_start_ff};
      `REG_X_END:     nxt_rdata = {4'h0, x_end_ff};
      `REG_Y_START:   nxt_rdata = {4'h0, y_start_ff};
      `REG_Y_END:     nxt_rdata = {4'h0, y_end_ff};
      `REG_X_OUT:     nxt_rdata = {4'h0, x_out_ff};
      `REG_Y_OUT:     nxt_rdata = {4'h0, y_out_ff};
      `REG_EXPOSURE:  nxt_rdata = {4'h0, exp_ff};
      `REG_SUBSAMPLE: nxt_rdata = {6'h00, sub_ff};
      `REG_STATUS:    nxt_rdata = status_w;
      default:        nxt_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_ff     <= 5'h00;
      x_start_ff  <= `X_START_RST; // R6
      x_end_ff    <= `X_END_RST;
      y_start_ff  <= `Y_START_RST;
      y_end_ff    <= `Y_END_RST;
      x_out_ff    <= `X_OUT_RST;
      y_out_ff    <= `Y_OUT_RST;
      exp_ff      <= `EXPOSURE_RST;
      sub_ff      <= 10'h000;
      reg_rdata_o <= 16'h0000;
    end else begin
      reg_rdata_o <= reg_rd_i ? nxt_rdata : 16'h0000;
      if (reg_wr_i) begin
        case (reg_addr_i)
          `REG_CTRL:      ctrl_ff <= {1'b0, reg_wdata_i[3:0]};
          `REG_X_START:   x_start_ff <= reg_wdata_i[11:0];
          `REG_X_END:     x_end_ff <= reg_wdata_i[11:0];
          `REG_Y_START:   y_start_ff <= reg_wdata_i[11:0];
          `REG_Y_END:     y_end_ff <= reg_wdata_i[11:0];
          `REG_X_OUT:     x_out_ff <= reg_wdata_i[11:0];
          `REG_Y_OUT:     y_out_ff <= reg_wdata_i[11:0];
          `REG_EXPOSURE:  exp_ff <= reg_wdata_i[11:0];
          `REG_SUBSAMPLE: sub_ff <= reg_wdata_i[9:0];
          default:        ;
        endcase
      end
    end
  end

  // state, frame latch and row stepping
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff  <= ST_IDLE;
      fr_ff     <= '0;
      gr_cnt_ff <= 8'h00;
      step_ff   <= 13'h0000;
      rs_act_ff <= 1'b0;
      rd_act_ff <= 1'b0;
      rs_o_ff   <= 13'h0000;
      rd_o_ff   <= 13'h0000;
      out_row_ff <= 12'h000;
      frame_cnt_ff <= 16'h0000;
    end else if (start_w) begin
      state_ff  <= ST_RUN;
      fr_ff     <= cfg_w; // R3 R20
      step_ff   <= 13'h0000;
      rs_act_ff <= !cfg_w.global_mode; // R1 R4
      rd_act_ff <= (cfg_w.exposure == 12'h000);
      rs_o_ff   <= 13'h0000;
      rd_o_ff   <= 13'h0000;
      out_row_ff <= 12'h000;
      frame_cnt_ff <= frame_cnt_ff + 16'(frame_end);
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (trig_w && reg_wdata_i[`CTRL_GLOBAL]) begin
            state_ff  <= ST_GRST; // R4
            fr_ff.global_mode <= 1'b1;
            gr_cnt_ff <= 8'h00;
          end
        end
        ST_GRST: gr_cnt_ff <= gr_cnt_ff + 8'h01;
        ST_RUN: begin
          if (step_tick) begin
            step_ff <= step_ff + 13'h0001;
            rs_o_ff <= nxt_rs_o; // R11
            if (nxt_rs_o > span_y)
              rs_act_ff <= 1'b0;
            if (step_ff + 13'h0001 == {1'b0, fr_ff.exposure}) begin
              rd_act_ff <= 1'b1; // R2
            end else if (rd_act_ff) begin
              rd_o_ff <= nxt_rd_o;
              if (out_row_ff != fr_ff.y_out)
                out_row_ff <= out_row_ff + 12'h001;
            end
            if (frame_end) begin
              rd_act_ff    <= 1'b0;
              state_ff     <= ST_IDLE;
              frame_cnt_ff <= frame_cnt_ff + 16'h0001;
            end
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // column walk then blanking, every step the same length
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      walk_ff      <= 1'b1;
      co_ff        <= 13'h0000;
      blank_cnt_ff <= 8'h00;
      out_col_ff   <= 12'h000;
    end else if (start_w || state_ff != ST_RUN || step_tick) begin
      walk_ff      <= 1'b1;
      co_ff        <= 13'h0000;
      blank_cnt_ff <= 8'h00;
      out_col_ff   <= 12'h000;
    end else if (walk_ff) begin
      co_ff <= nxt_co; // R11 R15
      if (out_col_ff != fr_ff.x_out)
        out_col_ff <= out_col_ff + 12'h001;
      if (nxt_co > span_x)
        walk_ff <= 1'b0;
    end else begin
      blank_cnt_ff <= blank_cnt_ff + 8'h01;
    end
  end

  wire run_walk = (state_ff == ST_RUN) && walk_ff && !start_w;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      row_rst_o      <= 1'b0;
      rst_row_o      <= 12'h000;
      pix_valid_o    <= 1'b0;
      col_addr_o     <= 12'h000;
      row_addr_o     <= 12'h000;
      nbr_col_o      <= 12'h000;
      frame_start_o  <= 1'b0;
      comb_bin_o     <= 1'b0;
      comb_sum_o     <= 1'b0;
      comb_vert_o    <= 1'b0;
      global_rst_o   <= 1'b0;
      shutter_open_o <= 1'b0;
    end else begin
      frame_start_o <= start_w;
      row_rst_o  <= run_walk && rs_act_ff && (co_ff == 13'h0000); // R1
      rst_row_o  <= rs_row_w;
      pix_valid_o <= run_walk && rd_act_ff && (out_col_ff < fr_ff.x_out)
                     && (out_row_ff < fr_ff.y_out); // R5
      col_addr_o <= col_w;
      row_addr_o <= rd_row_w;
      nbr_col_o  <= fr_ff.mirror ? col_w - nbr_d_w : col_w + nbr_d_w;
      comb_bin_o <= fr_ff.combine[0] | fr_ff.combine[1]; // R13
      comb_sum_o <= fr_ff.combine[2] | fr_ff.combine[3]; // R13 R16
      comb_vert_o <= comb_h_w && (fr_ff.combine[1] | fr_ff.combine[3]);
      global_rst_o <= (state_ff == ST_GRST) && (gr_cnt_ff != GR_CYC);
      shutter_open_o <= fr_ff.global_mode && (state_ff == ST_RUN)
                        && !rd_act_ff && !start_w; // R4
    end
  end

  // checks
  property p_exp_hold;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (state_ff == ST_RUN) && !start_w |=> $stable(fr_ff.exposure);
  endproperty
  a_exp_hold: assert property (p_exp_hold) // R3
    else $error("exposure changed inside a frame");
  property p_uniform;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    step_tick && rd_act_ff && !fr_ff.global_mode && !start_w
      |-> step_ff >= {1'b0, fr_ff.exposure};
  endproperty
  a_uniform: assert property (p_uniform) // R2
    else $error("row read before its exposure elapsed");
  property p_mirror_first;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    run_walk && co_ff == 13'h0000 |=>
      col_addr_o == ($past(fr_ff.mirror) ? $past(fr_ff.x_end)
                                         : $past(fr_ff.x_start));
  endproperty
  a_mirror_first: assert property (p_mirror_first) // R7
    else $error("row did not start at the mirrored edge");
  property p_flip_first;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    run_walk && rd_act_ff && rd_o_ff == 13'h0000 |=>
      row_addr_o == ($past(fr_ff.flip) ? $past(fr_ff.y_end)
                                       : $past(fr_ff.y_start));
  endproperty
  a_flip_first: assert property (p_flip_first) // R8
    else $error("frame did not start at the flipped edge");
  property p_order;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $changed(ctrl_ff[`CTRL_MIRROR]) && $stable({x_start_ff[0], x_end_ff[0]})
      && (x_start_ff[0] != x_end_ff[0]) |-> $changed(order_w[0]);
  endproperty
  a_order: assert property (p_order) // R9
    else $error("colour order ignored a mirror change");
  property p_skip;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    run_walk && co_ff[0] && !step_tick |=> co_ff == $past(co_ff)
      + 13'h0001 + ((13'h0001 << $past(fr_ff.skip_x)) << 1) - 13'h0002
      || !walk_ff || state_ff != ST_RUN || $past(nxt_co > span_x);
  endproperty
  a_skip: assert property (p_skip) // R10 R12
    else $error("column skip stride wrong");
  property p_width;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    pix_valid_o |-> $past(out_col_ff) < $past(fr_ff.x_out);
  endproperty
  a_width: assert property (p_width) // R5
    else $error("pixel beyond output width");
  property p_shutter;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $fell(global_rst_o) |-> ##1 shutter_open_o || rd_act_ff;
  endproperty
  a_shutter: assert property (p_shutter) // R4
    else $error("shutter not opened after global reset");
  c_roll_frame: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    frame_end && !fr_ff.global_mode);
  c_global: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $fell(shutter_open_o) ##[1:20] pix_valid_o);
  c_mirror: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    pix_valid_o && fr_ff.mirror && fr_ff.skip_x == 2'h2);
endmodule // pixel_array_readout_sequencer

// ---- rtl/readout_params.svh ----
// register map, field positions, reset values and timing counts
`ifndef READOUT_PARAMS_SVH
`define READOUT_PARAMS_SVH
`define REG_CTRL      4'h0
`define REG_X_START   4'h1
`define REG_X_END     4'h2
`define REG_Y_START   4'h3
`define REG_Y_END     4'h4
`define REG_X_OUT     4'h5
`define REG_Y_OUT     4'h6
`define REG_EXPOSURE  4'h7
`define REG_SUBSAMPLE 4'h8
`define REG_STATUS    4'h9
`define CTRL_STREAM   0
`define CTRL_GLOBAL   1
`define CTRL_MIRROR   2
`define CTRL_FLIP     3
`define CTRL_TRIGGER  4
`define SUB_SKX_LSB   0
`define SUB_SKY_LSB   2
`define SUB_BINX      5
`define SUB_BINXY     6
`define SUB_SUMX      7
`define SUB_SUMXY     8
`define SUB_BINALT    9
`define X_START_RST   12'h008
`define X_END_RST     12'hf07
`define Y_START_RST   12'h008
`define Y_END_RST     12'hac3
`define X_OUT_RST     12'hf00
`define Y_OUT_RST     12'habc
`define EXPOSURE_RST  12'h010
`define CLK_MHZ       20
`define GR_RST_NS     1000
`define GR_RST_CYC    ((`GR_RST_NS * `CLK_MHZ + 999) / 1000)
`endif

// ---- rtl/readout_pkg.sv ----
// types shared by the readout sequencer
package readout_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_GRST = 3'b010,
    ST_RUN  = 3'b100
  } seq_state_t;
  typedef struct packed {
    logic        global_mode;
    logic        mirror;
    logic        flip;
    logic [11:0] x_start;
    logic [11:0] x_end;
    logic [11:0] y_start;
    logic [11:0] y_end;
    logic [11:0] x_out;
    logic [11:0] y_out;
    logic [11:0] exposure;
    logic [1:0]  skip_x;
    logic [2:0]  skip_y;
    logic [4:0]  combine;
  } frame_cfg_t;
endpackage

// ---- verif/pixel_array_readout_sequencer_test.sv ----
// self-checking bench for the pixel array readout sequencer
`include "readout_params.svh"
module pixel_array_readout_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk_i;
  logic        rst_n_i;
  logic [3:0]  reg_addr_i;
  logic [15:0] reg_wdata_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic [15:0] reg_rdata_o;
  logic        row_rst_o;
  logic [11:0] rst_row_o;
  logic        pix_valid_o;
  logic [11:0] col_addr_o;
  logic [11:0] row_addr_o;
  logic [11:0] nbr_col_o;
  logic        frame_start_o;
  logic        comb_bin_o;
  logic        comb_sum_o;
  logic        comb_vert_o;
  logic        global_rst_o;
  logic        shutter_open_o;
  int          frames;
  int          cur_pix;
  int          last_pix;
  int          last_rows;
  logic [11:0] first_col;
  logic [11:0] first_row;
  int          last_int;
  int          nonuniform;
  int          fail_count;
  int          check_count;
  int          n;
  int          e2;
  int          f0;
  logic [15:0] s;
  logic [15:0] v [8];
  logic [11:0] dif;
  // legal subsampling words with expected {bin,sum,vert}, spacing, pixels
  localparam logic [15:0] sub_tbl [8] = '{16'h0005, 16'h0016, 16'h0021,
    16'h0221, 16'h0081, 16'h0082, 16'h0045, 16'h0105};
  localparam logic [2:0] cmb_tbl [8] = '{3'h0, 3'h0, 3'h4, 3'h4, 3'h2,
    3'h2, 3'h5, 3'h3};
  localparam int dst_tbl [8] = '{0, 0, 0, 4, 2, 2, 0, 2};
  localparam int px_tbl [8] = '{8, 4, 0, 0, 0, 0, 0, 0};

  pixel_array_readout_sequencer #(.LINE_BLANK(2)) u_pixel_array_readout_sequencer (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .row_rst_o(row_rst_o),
    .rst_row_o(rst_row_o), .pix_valid_o(pix_valid_o),
    .col_addr_o(col_addr_o), .row_addr_o(row_addr_o),
    .nbr_col_o(nbr_col_o), .frame_start_o(frame_start_o),
    .comb_bin_o(comb_bin_o), .comb_sum_o(comb_sum_o),
    .comb_vert_o(comb_vert_o), .global_rst_o(global_rst_o),
    .shutter_open_o(shutter_open_o));

  pixel_sink_model u_pixel_sink_model (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .frame_start_i(frame_start_o), .pix_valid_i(pix_valid_o),
    .col_i(col_addr_o), .row_i(row_addr_o), .row_rst_i(row_rst_o),
    .rst_row_i(rst_row_o), .frames_o(frames), .cur_pix_o(cur_pix),
    .last_pix_o(last_pix), .last_rows_o(last_rows),
    .first_col_o(first_col), .first_row_o(first_row),
    .last_int_o(last_int), .nonuniform_o(nonuniform));

  always #25 core_clk_i = ~core_clk_i;

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  task automatic timeout();
    fail_count++;
    test_done();
  endtask

  task automatic wait_frames(input int k);
    int t;
    t = frames + k;
    for (int i = 0; i < 20000 && frames < t; i++) @(posedge core_clk_i);
    #1;
    if (frames < t) timeout();
  endtask

  // 0 global reset, 1 shutter, 2 pixel valid
  task automatic wait_for(input int w, input logic lvl, output int c);
    c = 0;
    while ((w == 0 ? global_rst_o : w == 1 ? shutter_open_o : pix_valid_o)
           !== lvl) begin
      @(posedge core_clk_i);
      #1 c++;
      if (c > 20000) timeout();
    end
  endtask

  task automatic wait_idle();
    s = 16'hffff;
    for (int i = 0; i < 2000 && s[3] !== 1'b0; i++) rd(`REG_STATUS, s);
    if (s[3] !== 1'b0) timeout();
  endtask

  initial begin
    core_clk_i = 1'b0;
    rst_n_i = 1'b0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 16'h0000;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    fail_count = 0;
    check_count = 0;
    repeat (3) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    for (int i = 1; i < 8; i++) rd(4'(i), v[i]);
    chk(32'(v[2] - v[1] + 16'h1), 32'hf00);
    chk(32'(v[4] - v[3] + 16'h1), 32'habc);
    chk({v[5], v[6]}, 32'h0f00_0abc);
    rd(4'ha, s);
    chk(32'(s), 32'h0);
    wr(`REG_X_START, 16'h0008);
    wr(`REG_X_END, 16'h000f);
    wr(`REG_Y_START, 16'h0008);
    wr(`REG_Y_END, 16'h000b);
    wr(`REG_X_OUT, 16'h0008);
    wr(`REG_Y_OUT, 16'h0004);
    wr(`REG_EXPOSURE, 16'h0002);
    wr(`REG_CTRL, 16'h0001);
    wait_frames(3);
    chk(last_pix, 32'h20);
    chk(last_rows, 32'h4);
    chk({first_col, first_row}, 24'h008_008);
    e2 = last_int;
    wr(`REG_EXPOSURE, 16'h0004);
    wait_frames(3);
    chk(last_int, 32'(2 * e2));
    for (int m = 0; m < 4; m++) begin
      wr(`REG_CTRL, 16'(1 + 4 * m));
      wait_frames(3);
      chk(first_col, m[0] ? 32'hf : 32'h8);
      chk(first_row, m[1] ? 32'hb : 32'h8);
      rd(`REG_STATUS, s);
      chk(32'(s[2:1]), 32'(m[1:0]));
    end
    wr(`REG_CTRL, 16'h0001);
    wr(`REG_X_OUT, 16'h0006);
    wr(`REG_Y_OUT, 16'h0003);
    wait_frames(3);
    chk(last_pix, 32'h12);
    wr(`REG_X_OUT, 16'h0008);
    wr(`REG_Y_OUT, 16'h0004);
    for (int k = 0; k < 8; k++) begin
      wr(`REG_SUBSAMPLE, sub_tbl[k]);
      wait_frames(3);
      if (px_tbl[k] != 0) chk(last_pix, px_tbl[k]);
      wait_for(2, 1'b1, n);
      chk({comb_bin_o, comb_sum_o, comb_vert_o}, cmb_tbl[k]);
      dif = nbr_col_o > col_addr_o ? nbr_col_o - col_addr_o
                                   : col_addr_o - nbr_col_o;
      if (dst_tbl[k] != 0) chk(dif, dst_tbl[k]);
      rd(`REG_STATUS, s);
      chk(32'(s[4]), 32'h0);
    end
    chk(nonuniform, 32'h0);
    wr(`REG_CTRL, 16'h0000);
    wait_idle();
    wr(`REG_SUBSAMPLE, 16'h0145);
    rd(`REG_STATUS, s);
    chk(32'(s[4]), 32'h1);
    v[0] = s;
    wr(`REG_SUBSAMPLE, 16'h0000);
    f0 = frames;
    wr(`REG_CTRL, 16'h0012);
    wait_for(0, 1'b1, n);
    wait_for(0, 1'b0, n);
    chk(n, 32'(`GR_RST_CYC));
    wait_for(1, 1'b1, n);
    wait_for(1, 1'b0, n);
    wait_idle();
    chk(frames, 32'(f0 + 1));
    chk(cur_pix, 32'h20);
    chk(32'(s[15:5]), 32'(v[0][15:5] + 11'h001));
    test_done();
  end
endmodule // pixel_array_readout_sequencer_test

// ---- verif/pixel_sink_model.sv ----
// sink model of the downstream image processor: per-frame statistics
module pixel_sink_model (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        frame_start_i,
  input  wire logic        pix_valid_i,
  input  wire logic [11:0] col_i,
  input  wire logic [11:0] row_i,
  input  wire logic        row_rst_i,
  input  wire logic [11:0] rst_row_i,
  output int               frames_o,
  output int               cur_pix_o,
  output int               last_pix_o,
  output int               last_rows_o,
  output logic [11:0]      first_col_o,
  output logic [11:0]      first_row_o,
  output int               last_int_o,
  output int               nonuniform_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int          cyc;
  int          rows;
  int          ref_int;
  logic        have_pix;
  logic [11:0] cur_row;
  int          rst_cyc [int];
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cyc = 0;
      frames_o = 0;
      cur_pix_o = 0;
      rows = 0;
      have_pix = 1'b0;
      ref_int = -1;
      nonuniform_o = 0;
      rst_cyc.delete();
    end else begin
      cyc = cyc + 1;
      if (frame_start_i) begin
        frames_o = frames_o + 1;
        last_pix_o = cur_pix_o;
        last_rows_o = rows;
        cur_pix_o = 0;
        rows = 0;
        have_pix = 1'b0;
        ref_int = -1;
        rst_cyc.delete();
      end
      if (row_rst_i) rst_cyc[int'(rst_row_i)] = cyc;
      if (pix_valid_i) begin
        if (!have_pix) begin
          first_col_o = col_i;
          first_row_o = row_i;
        end
        if (!have_pix || row_i != cur_row) begin
          rows = rows + 1;
          cur_row = row_i;
          // reset-to-read spacing must match across the frame
          if (rst_cyc.exists(int'(row_i))) begin
            last_int_o = cyc - rst_cyc[int'(row_i)];
            if (ref_int < 0) ref_int = last_int_o;
            else if (ref_int != last_int_o) nonuniform_o++;
          end
        end
        have_pix = 1'b1;
        cur_pix_o = cur_pix_o + 1;
      end
    end
  end
endmodule // pixel_sink_model
